// ---- vbiss_pkg.sv ----
// constants, field layouts and carrier types for the vbi slicer settings and status bank
package vbiss_pkg;
  // two-wire port address; value is arbitrary
  localparam logic [6:0] VBISS_DEV_ADDR = 7'h21;
  // register offsets
  localparam logic [7:0] VBISS_OFF_PATTERN = 8'h58;
  localparam logic [7:0] VBISS_OFF_HLOW = 8'h59;
  localparam logic [7:0] VBISS_OFF_VLOW = 8'h5A;
  localparam logic [7:0] VBISS_OFF_FLAGS = 8'h5B;
  localparam logic [7:0] VBISS_OFF_IDENT = 8'h5D;
  localparam logic [7:0] VBISS_OFF_SECONDARY_IDENT_CODE = 8'h5E;
  localparam logic [7:0] VBISS_OFF_DETECT = 8'h60;
  localparam logic [7:0] VBISS_OFF_FLINE = 8'h61;
  localparam logic [7:0] VBISS_OFF_LTYPE = 8'h62;
  localparam logic [7:0] VBISS_OFF_GCTL = 8'h80;
  // reset values
  localparam logic [7:0] VBISS_RST_PATTERN = 8'h40;
  localparam logic [7:0] VBISS_RST_HLOW = 8'h47;
  localparam logic [7:0] VBISS_RST_VLOW = 8'h03;
  localparam logic [7:0] VBISS_RST_FLAGS = 8'h03;
  localparam logic [7:0] VBISS_RST_IDENT = 8'h00;
  localparam logic [5:0] VBISS_RST_SECONDARY_IDENT_CODE = 6'h00;
  localparam logic [7:0] VBISS_RST_GCTL = 8'h00;
  // writable bit masks, reserved bits read zero
  localparam logic [7:0] VBISS_MASK_FLAGS = 8'hD7;
  localparam logic [7:0] VBISS_MASK_IDENT = 8'hBF;
  // field positions
  localparam int VBISS_BIT_FLIP = 7;
  localparam int VBISS_BIT_RECODE = 6;
  localparam int VBISS_BIT_VMSB = 4;
  localparam int VBISS_BIT_REF = 7;
  localparam int VBISS_BIT_SCALER = 6;
  // line value limits
  localparam logic [8:0] VBISS_V_MAX = 9'h138;
  // identification codes selecting framing
  localparam logic [5:0] VBISS_DID_SAV_REF1 = 6'h3E;
  localparam logic [5:0] VBISS_DID_SAV_REF0 = 6'h3F;
  // data type codes
  localparam logic [3:0] VBISS_DK_VPS = 4'h2;
  localparam logic [3:0] VBISS_DK_CC525 = 4'h5;
  localparam logic [3:0] VBISS_DK_ACTIVE = 4'hF;
  // byte recoding
  localparam logic [7:0] VBISS_BYTE_ZERO = 8'h00;
  localparam logic [7:0] VBISS_BYTE_ONES = 8'hFF;
  localparam logic [7:0] VBISS_BYTE_ZERO_SUB = 8'h03;
  localparam logic [7:0] VBISS_BYTE_ONES_SUB = 8'hFC;
  localparam logic [3:0] VBISS_BITS_PER_BYTE = 4'h8;

  typedef enum logic [0:0] {
    VBISS_FRAME_ANC = 1'b0,
    VBISS_FRAME_SAV_EAV = 1'b1
  } vbiss_framing_type;

  typedef enum logic [3:0] {
    VBISS_ST_IDLE = 4'b0000,
    VBISS_ST_ADDR = 4'b0001,
    VBISS_ST_ADDR_ACK = 4'b0010,
    VBISS_ST_SUB = 4'b0011,
    VBISS_ST_SUB_ACK = 4'b0100,
    VBISS_ST_WDATA = 4'b0101,
    VBISS_ST_WDATA_ACK = 4'b0110,
    VBISS_ST_RDATA = 4'b0111,
    VBISS_ST_RDATA_ACK = 4'b1000
  } vbiss_port_state_type;

  typedef struct packed {
    logic exact;
    logic one_err;
    logic vps;
    logic wss;
    logic cc;
  } vbiss_detect_type;

  typedef struct packed {
    vbiss_detect_type seen;
    logic [8:0] line_index;
    logic [3:0] data_kind;
  } vbiss_status_type;

  typedef struct packed {
    logic [7:0] framing_pattern;
    logic [10:0] slice_h_start;
    logic [8:0] slice_v_start;
    logic [5:0] ident_code;
    logic [5:0] secondary_ident_code;
    vbiss_framing_type framing;
    logic scaler_from_slicer;
  } vbiss_cfg_type;
endpackage

// ---- vbiss_byte_recode.sv ----
// output byte recoder for sliced data
`timescale 1ns/1ps
`default_nettype none
module vbiss_byte_recode (
  input wire logic ref_clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic enable, // recode on
  input wire logic [7:0] data_in, // sliced byte
  input wire logic valid_in, // byte strobe
  output logic [7:0] data_out, // recoded byte
  output logic valid_out // recoded byte strobe
);
  import vbiss_pkg::*;
  wire logic [7:0] data_nxt;
  // keeps timing-reference values out of the payload
  assign data_nxt = !enable ? data_in :
                    (data_in == VBISS_BYTE_ZERO) ? VBISS_BYTE_ZERO_SUB :
                    (data_in == VBISS_BYTE_ONES) ? VBISS_BYTE_ONES_SUB : data_in;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      data_out <= VBISS_BYTE_ZERO;
      valid_out <= 1'b0;
    end else begin
      data_out <= data_nxt;
      valid_out <= valid_in;
    end
  end
  a_recode_ones: assert property (@(posedge ref_clk) disable iff (!resetn)
    (enable && data_in == VBISS_BYTE_ONES) |=> (data_out == VBISS_BYTE_ONES_SUB))
    else $error("ones byte not recoded");
endmodule
`default_nettype wire

// ---- vbiss_serial_port.sv ----
// two-wire serial control port slave with auto-incrementing subaddress
`timescale 1ns/1ps
`default_nettype none
module vbiss_serial_port #(
  parameter logic [6:0] DEV_ADDR = vbiss_pkg::VBISS_DEV_ADDR // slave address
) (
  input wire logic ref_clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic scl_in, // clock pin level
  input wire logic sda_in, // data pin level
  output logic sda_out, // data pin drive value
  output logic sda_oe_n, // data pin enable, low drives
  input wire logic [7:0] rd_data, // byte at reg_addr
  output logic [7:0] reg_addr, // current subaddress
  output logic [7:0] wr_data, // byte written
  output logic wr_stb // one-cycle write strobe
);
  import vbiss_pkg::*;
  logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r;
  vbiss_port_state_type state_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic rw_r, nack_r;
  wire logic start_seen, stop_seen, scl_rise, scl_fall, byte_end, drive_ack;
  assign start_seen = scl_s2_r && sda_d_r && !sda_s2_r;
  assign stop_seen = scl_s2_r && !sda_d_r && sda_s2_r;
  assign scl_rise = scl_s2_r && !scl_d_r;
  assign scl_fall = !scl_s2_r && scl_d_r;
  localparam logic [3:0] VBITS = VBISS_BITS_PER_BYTE;
  assign byte_end = scl_fall && (cnt_r == VBITS);
  assign drive_ack = (state_r == VBISS_ST_ADDR_ACK) || (state_r == VBISS_ST_SUB_ACK) ||
                     (state_r == VBISS_ST_WDATA_ACK);
  // open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe_n = !(drive_ack || (state_r == VBISS_ST_RDATA && !shift_r[7]));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= 3'h7;
      {sda_s1_r, sda_s2_r, sda_d_r} <= 3'h7;
    end else begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= {scl_in, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_d_r} <= {sda_in, sda_s1_r, sda_s2_r};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= VBISS_ST_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      reg_addr <= 8'h00;
      wr_data <= 8'h00;
      wr_stb <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      if (start_seen) begin
        state_r <= VBISS_ST_ADDR;
        cnt_r <= 4'h0;
      end else if (stop_seen) begin
        state_r <= VBISS_ST_IDLE;
      end else begin
        if (scl_rise) begin
          cnt_r <= cnt_r + 4'h1;
          if (state_r == VBISS_ST_RDATA_ACK) begin
            nack_r <= sda_s2_r;
          end else if (state_r != VBISS_ST_RDATA) begin
            shift_r <= {shift_r[6:0], sda_s2_r};
          end
        end
        case (state_r)
          VBISS_ST_ADDR: begin
            if (byte_end) begin
              rw_r <= shift_r[0];
              state_r <= (shift_r[7:1] == DEV_ADDR) ? VBISS_ST_ADDR_ACK : VBISS_ST_IDLE;
            end
          end
          VBISS_ST_SUB: begin
            if (byte_end) begin
              reg_addr <= shift_r;
              state_r <= VBISS_ST_SUB_ACK;
            end
          end
          VBISS_ST_WDATA: begin
            if (byte_end) begin
              wr_data <= shift_r;
              wr_stb <= 1'b1;
              state_r <= VBISS_ST_WDATA_ACK;
            end
          end
          VBISS_ST_RDATA: begin
            if (byte_end) begin
              state_r <= VBISS_ST_RDATA_ACK;
            end else if (scl_fall) begin
              shift_r <= {shift_r[6:0], 1'b0};
            end
          end
          VBISS_ST_ADDR_ACK, VBISS_ST_SUB_ACK, VBISS_ST_WDATA_ACK, VBISS_ST_RDATA_ACK: begin
            if (scl_fall) begin
              cnt_r <= 4'h0;
              if (state_r == VBISS_ST_WDATA_ACK) begin
                reg_addr <= reg_addr + 8'h01;
              end
              if ((state_r == VBISS_ST_ADDR_ACK && rw_r) ||
                  (state_r == VBISS_ST_RDATA_ACK && !nack_r)) begin
                shift_r <= rd_data;
                reg_addr <= reg_addr + 8'h01;
                state_r <= VBISS_ST_RDATA;
              end else if (state_r == VBISS_ST_RDATA_ACK) begin
                state_r <= VBISS_ST_IDLE;
              end else begin
                state_r <= (state_r == VBISS_ST_ADDR_ACK) ? VBISS_ST_SUB : VBISS_ST_WDATA;
              end
            end
          end
          VBISS_ST_IDLE: begin
            cnt_r <= 4'h0;
          end
          default: begin
            state_r <= VBISS_ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- vbiss_settings_status.sv ----
// vbi slicer settings and status register bank behind the serial control port
//
// Contract
// - 8-bit framing pattern for programmable data types, resets to 40H.
// - 11-bit horizontal start: upper three bits 5BH[2:0], lower byte 59H.
// - 9-bit vertical start: top bit 5BH[4], low byte 5AH, range 0 to 312.
// - field flip bit clear passes field indicator, set inverts it.
// - recode bit set maps bytes 00H to 03H and FFH to FCH.
// - reference select 0 uses per-line table, 1 uses decoder field and blanking.
// - ident 00H gives ancillary framing; 3EH/3FH give SAV/EAV with reference 1/0.
// - 6-bit secondary identification code, default zero.
// - status bit set when exact framing code seen last frame.
// - status bit set when framing code with one error seen last frame.
// - status bits for program service, widescreen signalling, captions seen last frame.
// - status bit reports slicer field identifier, zero in field 1.
// - 9-bit line number: high five bits 61H[4:0], low four 62H[7:4].
// - 62H[3:0] reports data type code applied to the current line.
// - global control bit 6 selects slicer or scaler window field timing.
// - data type codes: 0010 service, 0101 captions, 1111 active video default.
`timescale 1ns/1ps
`default_nettype none
module vbiss_settings_status #(
  parameter logic [6:0] DEV_ADDR = vbiss_pkg::VBISS_DEV_ADDR // serial port address
) (
  input wire logic ref_clk, // 10 MHz system clock
  input wire logic resetn, // async reset, active low
  input wire logic scl_in, // serial clock pin
  input wire logic sda_in, // serial data pin level
  output logic sda_out, // serial data drive value
  output logic sda_oe_n, // serial data enable, low drives
  input wire vbiss_pkg::vbiss_status_type slicer_status, // slicer detection results
  input wire logic frame_done, // one-cycle end-of-frame pulse
  input wire logic raw_field, // internal field indicator
  input wire logic table_field, // field from per-line type table
  input wire logic table_vblank, // blanking from per-line type table
  input wire logic decoder_even_field, // decoder real-time even field
  input wire logic decoder_vblank, // decoder real-time blanking
  input wire logic win_field, // scaler window field
  input wire logic win_vblank, // scaler window blanking
  input wire logic [7:0] slice_data, // sliced byte
  input wire logic slice_valid, // sliced byte strobe
  output vbiss_pkg::vbiss_cfg_type cfg, // settings to the slicer
  output logic slicer_field_id, // field indicator after flip
  output logic sliced_field, // field output of slicer
  output logic sliced_vblank, // blanking output of slicer
  output logic scaler_field, // scaler output field timing
  output logic scaler_vblank, // scaler output blanking timing
  output logic [7:0] out_data, // recoded sliced byte
  output logic out_valid // recoded byte strobe
);
  import vbiss_pkg::*;

  // ****************************************
  // register access
  // ****************************************
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  wire logic [7:0] reg_addr;
  wire logic [7:0] wr_data;
  wire logic wr_stb;
  logic [7:0] rd_data;

  vbiss_serial_port #(
    .DEV_ADDR(DEV_ADDR)
  ) u_port (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .rd_data(rd_data),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .wr_stb(wr_stb)
  );

  logic [7:0] pattern_r, hlow_r, vlow_r, flags_r, ident_r, gctl_r;
  logic [5:0] secondary_ident_code_r;
  vbiss_status_type stat_r;
  logic field_stat_r;

  wire logic wr_pattern, wr_hlow, wr_vlow, wr_flags, wr_ident, wr_secondary_ident_code, wr_gctl;
  assign wr_pattern = wr_stb && hit(reg_addr, VBISS_OFF_PATTERN);
  assign wr_hlow = wr_stb && hit(reg_addr, VBISS_OFF_HLOW);
  assign wr_vlow = wr_stb && hit(reg_addr, VBISS_OFF_VLOW);
  assign wr_flags = wr_stb && hit(reg_addr, VBISS_OFF_FLAGS);
  assign wr_ident = wr_stb && hit(reg_addr, VBISS_OFF_IDENT);
  assign wr_secondary_ident_code = wr_stb && hit(reg_addr, VBISS_OFF_SECONDARY_IDENT_CODE);
  assign wr_gctl = wr_stb && hit(reg_addr, VBISS_OFF_GCTL);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pattern_r <= VBISS_RST_PATTERN;
      hlow_r <= VBISS_RST_HLOW;
      vlow_r <= VBISS_RST_VLOW;
      flags_r <= VBISS_RST_FLAGS;
      ident_r <= VBISS_RST_IDENT;
      secondary_ident_code_r <= VBISS_RST_SECONDARY_IDENT_CODE;
      gctl_r <= VBISS_RST_GCTL;
    end else begin
      if (wr_pattern) pattern_r <= wr_data;
      if (wr_hlow) hlow_r <= wr_data;
      if (wr_vlow) vlow_r <= wr_data;
      if (wr_flags) flags_r <= wr_data & VBISS_MASK_FLAGS;
      if (wr_ident) ident_r <= wr_data & VBISS_MASK_IDENT;
      if (wr_secondary_ident_code) secondary_ident_code_r <= wr_data[5:0];
      if (wr_gctl) gctl_r <= wr_data;
    end
  end

  // ****************************************
  // status capture
  // ****************************************
  // no write path reaches these: host writes to 60H-62H fall through
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stat_r <= '{seen: '0, line_index: 9'h000, data_kind: VBISS_DK_ACTIVE};
      field_stat_r <= 1'b0;
    end else if (frame_done) begin
      stat_r <= slicer_status;
      field_stat_r <= slicer_field_id;
    end
  end

  wire logic [7:0] detect_byte, fline_byte, ltype_byte;
  assign detect_byte = {1'b0, stat_r.seen.exact, stat_r.seen.one_err, stat_r.seen.vps,
                        stat_r.seen.wss, stat_r.seen.cc, 2'b00};
  assign fline_byte = {2'b00, field_stat_r, stat_r.line_index[8:4]};
  assign ltype_byte = {stat_r.line_index[3:0], stat_r.data_kind};

  always_comb begin
    rd_data = 8'h00;
    if (hit(reg_addr, VBISS_OFF_PATTERN)) rd_data = pattern_r;
    if (hit(reg_addr, VBISS_OFF_HLOW)) rd_data = hlow_r;
    if (hit(reg_addr, VBISS_OFF_VLOW)) rd_data = vlow_r;
    if (hit(reg_addr, VBISS_OFF_FLAGS)) rd_data = flags_r;
    if (hit(reg_addr, VBISS_OFF_IDENT)) rd_data = ident_r;
    if (hit(reg_addr, VBISS_OFF_SECONDARY_IDENT_CODE)) rd_data = {2'b00, secondary_ident_code_r};
    if (hit(reg_addr, VBISS_OFF_DETECT)) rd_data = detect_byte;
    if (hit(reg_addr, VBISS_OFF_FLINE)) rd_data = fline_byte;
    if (hit(reg_addr, VBISS_OFF_LTYPE)) rd_data = ltype_byte;
    if (hit(reg_addr, VBISS_OFF_GCTL)) rd_data = gctl_r;
  end

  // ****************************************
  // derived settings
  // ****************************************
  wire logic [8:0] v_raw, v_eff;
  wire logic [5:0] did;
  wire logic sav_mode, ref_eff, field_nxt, vblank_nxt;
  vbiss_cfg_type cfg_nxt;

  assign v_raw = {flags_r[VBISS_BIT_VMSB], vlow_r};
  // out-of-range values saturate instead of wrapping into a bogus line
  assign v_eff = (v_raw > VBISS_V_MAX) ? VBISS_V_MAX : v_raw;
  assign did = ident_r[5:0];
  assign sav_mode = (did == VBISS_DID_SAV_REF1) || (did == VBISS_DID_SAV_REF0);
  assign ref_eff = (did == VBISS_DID_SAV_REF1) ? 1'b1 :
                   (did == VBISS_DID_SAV_REF0) ? 1'b0 : ident_r[VBISS_BIT_REF];
  assign field_nxt = ref_eff ? decoder_even_field : table_field;
  assign vblank_nxt = ref_eff ? decoder_vblank : table_vblank;

  always_comb begin
    cfg_nxt.framing_pattern = pattern_r;
    cfg_nxt.slice_h_start = {flags_r[2:0], hlow_r};
    cfg_nxt.slice_v_start = v_eff;
    cfg_nxt.ident_code = did;
    cfg_nxt.secondary_ident_code = secondary_ident_code_r;
    cfg_nxt.framing = sav_mode ? VBISS_FRAME_SAV_EAV : VBISS_FRAME_ANC;
    cfg_nxt.scaler_from_slicer = gctl_r[VBISS_BIT_SCALER];
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg <= '0;
      slicer_field_id <= 1'b0;
      sliced_field <= 1'b0;
      sliced_vblank <= 1'b0;
      scaler_field <= 1'b0;
      scaler_vblank <= 1'b0;
    end else begin
      cfg <= cfg_nxt;
      slicer_field_id <= raw_field ^ flags_r[VBISS_BIT_FLIP];
      sliced_field <= field_nxt;
      sliced_vblank <= vblank_nxt;
      scaler_field <= gctl_r[VBISS_BIT_SCALER] ? field_nxt : win_field;
      scaler_vblank <= gctl_r[VBISS_BIT_SCALER] ? vblank_nxt : win_vblank;
    end
  end

  vbiss_byte_recode u_recode (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .enable(flags_r[VBISS_BIT_RECODE]),
    .data_in(slice_data),
    .valid_in(slice_valid),
    .data_out(out_data),
    .valid_out(out_valid)
  );

  // ****************************************
  // checks
  // ****************************************
  a_pattern_write: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_pattern |=> ##1 (cfg.framing_pattern == $past(wr_data, 2)))
    else $error("framing pattern not forwarded");
  a_h_start_low: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_hlow |=> ##1 (cfg.slice_h_start[7:0] == $past(wr_data, 2)))
    else $error("horizontal start low byte wrong");
  a_v_start_range: assert property (@(posedge ref_clk) disable iff (!resetn)
    cfg.slice_v_start <= VBISS_V_MAX)
    else $error("vertical start above limit");
  a_field_flip: assert property (@(posedge ref_clk) disable iff (!resetn)
    flags_r[VBISS_BIT_FLIP] |=> (slicer_field_id != $past(raw_field)))
    else $error("field indicator not inverted");
  a_ref_table: assert property (@(posedge ref_clk) disable iff (!resetn)
    !ref_eff |=> (sliced_field == $past(table_field)))
    else $error("table field not selected");
  a_did_sav: assert property (@(posedge ref_clk) disable iff (!resetn)
    (did == VBISS_DID_SAV_REF0) |=> (cfg.framing == VBISS_FRAME_SAV_EAV) && !$past(ref_eff))
    else $error("ident 3F framing wrong");
  a_status_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    !frame_done |=> $stable(ltype_byte) && $stable(detect_byte) && $stable(fline_byte))
    else $error("status changed outside frame end");
  a_status_exact: assert property (@(posedge ref_clk) disable iff (!resetn)
    frame_done |=> (detect_byte[6] == $past(slicer_status.seen.exact)))
    else $error("exact pattern flag not captured");
  a_scaler_window: assert property (@(posedge ref_clk) disable iff (!resetn)
    !gctl_r[VBISS_BIT_SCALER] |=> (scaler_vblank == $past(win_vblank)))
    else $error("scaler window timing not used");
endmodule
`default_nettype wire

// ---- vbiss_host_model.sv ----
// host controller model driving the two-wire serial control port
`timescale 1ns/1ps
`default_nettype none
module vbiss_host_model (
  input wire logic ref_clk, // system clock
  input wire logic sda_line, // resolved data line level
  output var logic scl, // serial clock, idles high
  output var logic sda_rel // high releases the data line
);
  import vbiss_pkg::*;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // five clocks a phase keeps every scl level well above the four-clock minimum;
  // pins move on the falling edge so the port's sampling edge never races them
  task automatic half();
    repeat (5) @(negedge ref_clk);
  endtask
  task automatic clk_bit(input logic b, output logic s);
    sda_rel = b;
    half();
    scl = 1'b1;
    half();
    s = sda_line;
    scl = 1'b0;
    half();
  endtask
  task automatic start_c();
    sda_rel = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_rel = 1'b0;
    half();
    scl = 1'b0;
    half();
  endtask
  task automatic stop_c();
    sda_rel = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_rel = 1'b1;
    half();
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] sub, input logic [7:0] dat,
                    output logic [2:0] ack);
    start_c();
    put({dev, 1'b0}, ack[2]);
    put(sub, ack[1]);
    put(dat, ack[0]);
    stop_c();
  endtask
  // single byte read, last byte answered with a nack
  task automatic rd(input logic [7:0] sub, output logic [7:0] d);
    logic a;
    start_c();
    put({VBISS_DEV_ADDR, 1'b0}, a);
    put(sub, a);
    start_c();
    put({VBISS_DEV_ADDR, 1'b1}, a);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(1'b1, a);
    stop_c();
  endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the vbi slicer settings and status bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vbiss_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0, frame_done = 1'b0, raw_field = 1'b0;
  logic table_field = 1'b1, table_vblank = 1'b0, decoder_even_field = 1'b0;
  logic decoder_vblank = 1'b1, win_field = 1'b0, win_vblank = 1'b0, slice_valid = 1'b0;
  logic [7:0] slice_data = 8'h00;
  vbiss_status_type slicer_status = '0;
  logic scl, sda_rel, sda_out, sda_oe_n, slicer_field_id, sliced_field, sliced_vblank;
  logic scaler_field, scaler_vblank, out_valid;
  logic [7:0] out_data, rdat;
  logic [2:0] ack;
  vbiss_cfg_type cfg;
  int num_errors = 0, compares = 0;
  logic [15:0] rst_rows [0:4] = '{16'h5840, 16'h5E00, 16'h6000, 16'h6100, 16'h620F};
  // subaddress, byte written, byte read back
  logic [23:0] rows [0:8] = '{24'h58AAAA, 24'h591212, 24'h5AFFFF, 24'h5BFFD7, 24'h5DFFBF,
                              24'h5EFF3F, 24'h805A5A, 24'h62000F, 24'h705500};
  // ident byte, effective reference, framing
  logic [9:0] ids [0:3] = '{10'h0FD, 10'h0FB, 10'h000, 10'h202};
  // pull-up on the open-drain data line
  wire logic sda_line = sda_rel & (sda_oe_n | sda_out);
  always #50 ref_clk = ~ref_clk;
  vbiss_host_model u_vbiss_host_model (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl),
    .sda_rel(sda_rel));
  vbiss_settings_status u_vbiss_settings_status (.ref_clk(ref_clk), .resetn(resetn),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .slicer_status(slicer_status), .frame_done(frame_done), .raw_field(raw_field),
    .table_field(table_field), .table_vblank(table_vblank),
    .decoder_even_field(decoder_even_field), .decoder_vblank(decoder_vblank),
    .win_field(win_field), .win_vblank(win_vblank), .slice_data(slice_data),
    .slice_valid(slice_valid), .cfg(cfg), .slicer_field_id(slicer_field_id),
    .sliced_field(sliced_field), .sliced_vblank(sliced_vblank), .scaler_field(scaler_field),
    .scaler_vblank(scaler_vblank), .out_data(out_data), .out_valid(out_valid));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] sub, input logic [7:0] dat);
    u_vbiss_host_model.wr(VBISS_DEV_ADDR, sub, dat, ack);
    chk({13'h0000, ack}, 16'h0007);
  endtask
  task automatic rdc(input logic [7:0] sub, input logic [7:0] exp);
    u_vbiss_host_model.rd(sub, rdat);
    chk({8'h00, rdat}, {8'h00, exp});
  endtask
  task automatic byte_chk(input logic [7:0] din, input logic [7:0] exp);
    slice_data = din;
    slice_valid = 1'b1;
    tick(3);
    chk({7'h00, out_valid, out_data}, {8'h01, exp});
    slice_valid = 1'b0;
    tick(1);
  endtask
  task automatic frame(input logic [17:0] st);
    slicer_status = st;
    frame_done = 1'b1;
    tick(1);
    frame_done = 1'b0;
    slicer_status = 18'h0000F;
    tick(2);
  endtask
  // a full run needs about 22000 clocks
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    close_out();
  end
  initial begin
    tick(6);
    resetn = 1'b1;
    tick(4);
    chk({8'h00, cfg.framing_pattern}, 16'h0040);
    chk({5'h00, cfg.slice_h_start}, 16'h0347);
    for (int i = 0; i < 5; i++) begin
      rdc(rst_rows[i][15:8], rst_rows[i][7:0]);
    end
    for (int i = 0; i < 9; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rdc(rows[i][23:16], rows[i][7:0]);
    end
    chk({5'h00, cfg.slice_h_start}, 16'h0712);
    chk({7'h00, cfg.slice_v_start}, 16'h0138);
    chk({10'h000, cfg.secondary_ident_code}, 16'h003F);
    chk({15'h0000, cfg.scaler_from_slicer}, 16'h0001);
    u_vbiss_host_model.wr(VBISS_DEV_ADDR ^ 7'h01, 8'h58, 8'h11, ack);
    chk({13'h0000, ack}, 16'h0000);
    rdc(8'h58, 8'hAA);
    for (int i = 0; i < 4; i++) begin
      wr(VBISS_OFF_IDENT, ids[i][9:2]);
      tick(3);
      chk({15'h0000, cfg.framing}, {15'h0000, ids[i][0]});
      chk({10'h000, cfg.ident_code}, {10'h000, ids[i][7:2]});
      chk({14'h0000, sliced_field, sliced_vblank}, ids[i][1] ? 16'h0001 : 16'h0002);
      chk({14'h0000, scaler_field, scaler_vblank}, ids[i][1] ? 16'h0001 : 16'h0002);
    end
    wr(VBISS_OFF_GCTL, 8'h00);
    win_field = 1'b1;
    tick(3);
    chk({14'h0000, scaler_field, scaler_vblank}, 16'h0002);
    raw_field = 1'b1;
    tick(3);
    chk({15'h0000, slicer_field_id}, 16'h0000);
    byte_chk(8'h00, 8'h03);
    byte_chk(8'hFF, 8'hFC);
    byte_chk(8'h5A, 8'h5A);
    wr(VBISS_OFF_FLAGS, 8'h03);
    tick(3);
    chk({15'h0000, slicer_field_id}, 16'h0001);
    chk({7'h00, cfg.slice_v_start}, 16'h00FF);
    byte_chk(8'h00, 8'h00);
    wr(VBISS_OFF_VLOW, 8'h06);
    tick(3);
    chk({7'h00, cfg.slice_v_start}, 16'h0006);
    slicer_status = {5'b10101, 9'h1A5, 4'h5};
    tick(2);
    rdc(VBISS_OFF_DETECT, 8'h00);
    frame({5'b10101, 9'h1A5, 4'h5});
    raw_field = 1'b0;
    rdc(VBISS_OFF_DETECT, 8'h54);
    rdc(VBISS_OFF_FLINE, 8'h3A);
    rdc(VBISS_OFF_LTYPE, 8'h55);
    wr(VBISS_OFF_DETECT, 8'hFF);
    rdc(VBISS_OFF_DETECT, 8'h54);
    frame({5'b01010, 9'h05A, 4'hF});
    rdc(VBISS_OFF_DETECT, 8'h28);
    rdc(VBISS_OFF_FLINE, 8'h05);
    rdc(VBISS_OFF_LTYPE, 8'hAF);
    close_out();
  end
endmodule
`default_nettype wire
